/* bench/pin_load.sv */
// far side model: count pin pulser with pull-up, direction pin
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic core_clk, // peripheral clock
  input  wire logic pulseReq, // ask for one low pulse
  input  wire logic dirLvl,   // wanted direction level
  input  wire logic pinOut,   // device drive level
  input  wire logic pinOe,    // device drives the pin
  output logic      pinLine,  // resolved pin level
  output logic      dirPin    // direction pin level
);
  logic lowNow = 1'b0;
  // one cycle low pulse, otherwise the pull-up holds the line high
  always_ff @(posedge core_clk) lowNow <= pulseReq;
  assign pinLine = pinOe ? pinOut : !lowNow;
  assign dirPin = dirLvl;
endmodule
`default_nettype wire

/* bench/reload_timer_clock_out_chk.sv */
// port checker for the reload timer
`timescale 1ns/1ps
`default_nettype none
module reload_timer_clock_out_chk (
  input wire logic        core_clk,    // clock
  input wire logic        rst_b,       // reset, active low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb access
  input wire logic        pwrite,      // apb write
  input wire logic [7:0]  paddr,       // apb address
  input wire logic [31:0] pwdata,      // apb write data
  input wire logic [31:0] prdata,      // apb read data
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic        countPinOut, // clock-out level
  input wire logic        countPinOe,  // pin drive enable
  input wire logic        rxBaudTick,  // receive clock pulse
  input wire logic        txBaudTick   // transmit clock pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic mapped;
  logic cfgWr;
  // access phase, address decode and configuration writes
  assign acc = psel && penable;
  assign mapped = paddr <= reload_timer_pkg::OFS_RLD_HIGH && paddr[1:0] == 2'h0;
  assign cfgWr = acc && pwrite && paddr inside {reload_timer_pkg::OFS_CONTROL, reload_timer_pkg::OFS_MODE};
  chk_ready_high: assert property (acc |-> pready) else $error("pready low in access");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
  chk_oe_by_write: assert property ($changed(countPinOe) |-> $past(cfgWr))
    else $error("pin drive changed without write");
  chk_oe_rise_cfg: assert property ($rose(countPinOe) |->
    $past(paddr == reload_timer_pkg::OFS_MODE ? pwdata[1] : !pwdata[1]))
    else $error("pin drive rose on wrong setting");
  chk_clkout_half: assert property ($changed(countPinOut) |=> $stable(countPinOut))
    else $error("clock-out half period too short");
  chk_rx_single: assert property (rxBaudTick |=> !rxBaudTick) else $error("rx tick too long");
  chk_tx_single: assert property (txBaudTick |=> !txBaudTick) else $error("tx tick too long");
  cover property ($changed(countPinOut));
  cover property (rxBaudTick);
  cover property (acc && !mapped);
endmodule
bind reload_timer_clock_out reload_timer_clock_out_chk chk (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .countPinOut, .countPinOe, .rxBaudTick, .txBaudTick);
`default_nettype wire

/* bench/reload_timer_clock_out_tb.sv */
// self-checking testbench for the reload timer
`timescale 1ns/1ps
`default_nettype none
module reload_timer_clock_out_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, line, pinOut, pinOe, dirPin, irq, rxT, txT;
  logic dirLvl = 1'b1;
  logic pulseReq = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  int c;
  reload_timer_clock_out #(.PRESCALE(2)) dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countPinIn(line), .countPinOut(pinOut), .countPinOe(pinOe), .directionPin(dirPin),
    .timerIrq(irq), .rxBaudTick(rxT), .txBaudTick(txT));
  pin_load far (.core_clk(core_clk), .pulseReq(pulseReq), .dirLvl(dirLvl), .pinOut(pinOut),
    .pinOe(pinOe), .pinLine(line), .dirPin(dirPin));
  // 50 MHz clock
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // counts edges until s reaches want, bounded
  task automatic gap(ref logic s, input logic want, output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (s !== want && n < 400);
    if (n >= 400)
    begin
      failures++;
      end_sim();
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    gap(pready, 1'b1, n);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never re-drives psel in this time step
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic pulses(input int k);
    repeat (k)
    begin
      pulseReq <= 1'b1;
      @(posedge core_clk);
      pulseReq <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h18, 32'h0);
    $display("reset test done");
    wr(8'h00, 32'h06);
    pulses(5);
    wr(8'h00, 32'h0);
    pulses(1);
    rd(8'h08, 32'h05);
    $display("counter test done");
    wr(8'h10, 32'h34);
    wr(8'h14, 32'h12);
    wr(8'h08, 32'hfe);
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h04);
    gap(irq, 1'b1, c);
    rd(8'h00, 32'h84);
    wr(8'h00, 32'h0);
    @(posedge core_clk);
    chk(irq, 1'b0);
    rd(8'h0c, 32'h12);
    $display("reload test done");
    wr(8'h04, 32'h01);
    dirLvl <= 1'b0;
    wr(8'h10, 32'h10);
    wr(8'h14, 32'h00);
    wr(8'h08, 32'h12);
    wr(8'h0c, 32'h00);
    wr(8'h00, 32'h04);
    gap(irq, 1'b1, c);
    rd(8'h00, 32'hc4);
    wr(8'h00, 32'h0);
    rd(8'h0c, 32'hff);
    dirLvl <= 1'b1;
    wr(8'h08, 32'hfe);
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h04);
    gap(irq, 1'b1, c);
    rd(8'h00, 32'hc4);
    wr(8'h00, 32'h0);
    rd(8'h0c, 32'h00);
    wr(8'h04, 32'h0);
    $display("up/down test done");
    wr(8'h10, 32'h21);
    wr(8'h14, 32'h43);
    wr(8'h00, 32'h0c);
    dirLvl <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(8'h00, 32'h4c);
    wr(8'h00, 32'h0);
    rd(8'h0c, 32'h43);
    $display("external test done");
    dirLvl <= 1'b1;
    wr(8'h08, 32'h00);
    wr(8'h0c, 32'h55);
    wr(8'h00, 32'h0d);
    dirLvl <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(8'h00, 32'h4d);
    wr(8'h00, 32'h0);
    rd(8'h14, 32'h55);
    $display("capture test done");
    wr(8'h04, 32'h02);
    wr(8'h10, 32'hfd);
    wr(8'h14, 32'hff);
    wr(8'h08, 32'hfd);
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h04);
    chk(pinOe, 1'b1);
    gap(pinOut, !pinOut, c);
    gap(pinOut, !pinOut, c);
    chk(c, 6);
    gap(pinOut, !pinOut, c);
    chk(c, 6);
    chk(line, pinOut);
    chk(irq, 1'b0);
    wr(8'h00, 32'h34);
    gap(rxT, 1'b1, c);
    gap(rxT, 1'b1, c);
    chk(c, 6);
    gap(txT, 1'b1, c);
    chk(c, 6);
    gap(pinOut, !pinOut, c);
    gap(pinOut, !pinOut, c);
    chk(c, 6);
    rd(8'h00, 32'h34);
    $display("clock-out test done");
    end_sim();
  end
endmodule
`default_nettype wire

/* hdl/fall_edge_detect.sv */
// falling edge detector for a synchronous input pin
`timescale 1ns/1ps
`default_nettype none
module fall_edge_detect (
  input  wire logic core_clk, // peripheral clock
  input  wire logic rst_b,    // synchronous reset, active low
  input  wire logic pinIn,    // sampled pin level
  output logic      fallPulse // one cycle pulse on a high to low step
);
  typedef struct packed {
    logic prevLevel;
  } edge_s;
  edge_s state_r;
  edge_s state_nxt;

  // remember the last level
  always_comb
  begin
    state_nxt.prevLevel = pinIn;
  end

  // reset to high, so a pin low at release gives one fall pulse in the first cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state_r <= '{prevLevel: 1'b1};
    else
      state_r <= state_nxt;
  end

  assign fallPulse = state_r.prevLevel & ~pinIn;
endmodule
`default_nettype wire

/* hdl/reload_timer_clock_out.sv */
// 16-bit reload timer with up/down auto-reload, capture and clock-out, behind an apb slave
// How it works
// - count is low byte and high byte cascaded, low carrying into high
// - counter_select picks divided internal clock or count_pin pulses
// - count advances only while run_control is set
// - capture, auto-reload and baud modes chosen by clock selects and capture bit
// - down_count_enable clear: plain up-count, reload on overflow
// - down_count_enable set: direction_pin level sets count direction
// - counting up, overflow past ffff sets flag, interrupts, loads reload value
// - counting down, count equal reload sets flag and loads ffff
// - up/down mode toggles external_flag on each wrap, kept out of the interrupt
// - clock-out mode makes a 50 percent duty clock
// - clock-out mode advances the count at half the peripheral clock
// - clock-out mode reloads at each overflow without interrupts
// - clock-out frequency is clock over four times 65536 minus reload
// - generated clock drives the count_pin output
// - baud generation and clock-out may run together on shared reload
// - overflow_flag set only with both clock selects clear; software clears it
// - counter operation counts count_pin falling edges
// - external_enable set: direction_pin fall reloads or captures, sets external_flag
// - receive clock select routes overflows to serial receive clock
//
// register map, one byte in each aligned word, upper bits read as zero
//   0x00 control : overflow flag, external flag, receive select, transmit select,
//                  external enable, run, counter select, capture select (bit 7 down to 0)
//   0x04 mode    : clock-out enable in bit 1, down count enable in bit 0
//   0x08 count   : low byte, writable at any time
//   0x0c count   : high byte, writable at any time
//   0x10 reload  : low byte, also the capture target
//   0x14 reload  : high byte, also the capture target
//   other        : read zero, writes dropped, pslverr in the access phase
//
// mode decode, highest priority first, all with run set
//   receive or transmit select : baud generation, one step every second clock
//   clock-out enable, timer    : clock-out, one step every second clock
//   capture select             : capture on a direction pin fall with external enable
//   down count enable          : up/down auto-reload, direction taken from the pin level
//   none of these              : up-count auto-reload from the reload bytes
//
// count sources
//   timer   : one step every PRESCALE clocks from the internal divider
//   counter : one step in the cycle after a falling edge of the count pin
//   the divider restarts whenever run is cleared, so the first step after a
//   start comes a full PRESCALE clocks later
//
// wrap handling
//   counting up, the wrap is the step taken at the all-ones count
//   counting down, the wrap is the step taken at a count equal to the reload value
//   a down wrap loads all ones, every other wrap loads the reload value,
//   except in capture mode where the count simply rolls over to zero
//   in up/down mode the external flag toggles on every wrap and acts as a
//   seventeenth count bit, so it is kept out of the interrupt request
//
// clock-out
//   the half rate phase bit gives one step every second clock and the output
//   level toggles at each wrap, so one output period is two wrap intervals:
//   4 * (65536 - reload) clocks, e.g. reload 0xfffd gives a 12 clock period
//   the initial count only sets the length of the first half period
//   overflow flag and overflow interrupt stay quiet in this mode
//   the pin output enable follows clock-out enable with counter select clear,
//   so the pin is never counted while the block drives it
//
// bus timing
//   pready is tied high, every transfer is one setup and one access cycle
//   read data is latched in the setup cycle and stands until the next read
//   a write lands at the access edge; a hardware flag set in that same
//   cycle wins over the software value
//
// reset
//   synchronous and active low; every register but the edge detectors clears, pready stays high
//   the edge detectors come out of reset expecting a high pin, so a pin held
//   low through reset gives one fall pulse, which the cleared run bit ignores
//   one reset clock is enough, both detectors load a high level whatever the pin does
//
// pins
//   count pin is an input in timer and counter use and an output in clock-out
//   direction pin is read as a level for up/down and as a falling edge for
//   external reload and capture
//   both pins are taken as synchronous to the peripheral clock
//
// limitations
//   the count bytes are not latched as a pair: software reading a running
//   count reads high, low, high again and retries when the high byte moved
//   baud ticks and clock-out share one reload value, so their rates are tied
//   external events are ignored while run is clear and in up/down mode
`timescale 1ns/1ps
`default_nettype none
module reload_timer_clock_out #(
  parameter int PRESCALE = reload_timer_pkg::TIMER_DIV // internal timer divide ratio
) (
  input  wire logic        core_clk,      // peripheral clock, 50 MHz
  input  wire logic        rst_b,         // synchronous reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic        countPinIn,    // count_pin level
  output logic             countPinOut,   // clock-out level on count_pin
  output logic             countPinOe,    // count_pin driven while high
  input  wire logic        directionPin,  // direction_pin level
  output logic             timerIrq,      // interrupt request level
  output logic             rxBaudTick,    // serial receive clock pulse
  output logic             txBaudTick     // serial transmit clock pulse
);
  // refuse settings and constants that the logic cannot serve
  initial
  begin
    if (PRESCALE < 1 || PRESCALE > 255)
      $error("reload_timer_clock_out: PRESCALE out of range");
    if (reload_timer_pkg::CTL_OVERFLOW > 7 || reload_timer_pkg::CTL_CAPTURE < 0)
      $error("reload_timer_clock_out: control field outside the byte");
    if (reload_timer_pkg::MOD_CLKOUT > 1 || reload_timer_pkg::MOD_DOWNEN < 0)
      $error("reload_timer_clock_out: mode field outside the stored bits");
    if (reload_timer_pkg::OFS_CONTROL[1:0] != 2'h0 || reload_timer_pkg::OFS_MODE[1:0] != 2'h0)
      $error("reload_timer_clock_out: control or mode offset not word aligned");
    if (reload_timer_pkg::OFS_CNT_LOW[1:0] != 2'h0 || reload_timer_pkg::OFS_CNT_HIGH[1:0] != 2'h0)
      $error("reload_timer_clock_out: count offset not word aligned");
    if (reload_timer_pkg::OFS_RLD_LOW[1:0] != 2'h0 || reload_timer_pkg::OFS_RLD_HIGH[1:0] != 2'h0)
      $error("reload_timer_clock_out: reload offset not word aligned");
  end

  typedef struct packed {
    logic [7:0]  control;     // timer_control_reg
    logic [1:0]  mode;        // timer_mode_reg used bits
    logic [15:0] count;       // count_high_byte : count_low_byte
    logic [15:0] reload;      // reload_high_byte : reload_low_byte
    logic        halfPhase;   // clock-out half rate phase
    logic        clkOut;      // clock-out level
    logic        rxTick;      // registered receive clock pulse
    logic        txTick;      // registered transmit clock pulse
    logic [31:0] rdata;       // registered read data
  } timer_s;
  timer_s state_r;
  timer_s state_nxt;

  logic        preTick;
  logic        pinFall;
  logic        dirFall;
  logic        runBit;
  logic        counterSel;
  logic        captureSel;
  logic        rxSel;
  logic        txSel;
  logic        baudMode;
  logic        clkOutMode;
  logic        downMode;
  logic        step;
  logic        countDown;
  logic        wrap;
  logic        extEvent;
  logic        wrAccess;
  logic        rdAccess;
  logic        addrOk;
  logic [15:0] upNext;
  logic [7:0]  lowNext;
  logic [7:0]  highNext;
  logic        lowCarry;

  // control and mode bits
  assign runBit     = state_r.control[reload_timer_pkg::CTL_RUN];
  assign counterSel = state_r.control[reload_timer_pkg::CTL_COUNTER];
  assign captureSel = state_r.control[reload_timer_pkg::CTL_CAPTURE];
  assign rxSel      = state_r.control[reload_timer_pkg::CTL_RXCLK];
  assign txSel      = state_r.control[reload_timer_pkg::CTL_TXCLK];
  assign baudMode   = rxSel | txSel;
  assign clkOutMode = state_r.mode[reload_timer_pkg::MOD_CLKOUT] & ~counterSel;
  assign downMode   = state_r.mode[reload_timer_pkg::MOD_DOWNEN] & ~captureSel & ~baudMode & ~clkOutMode;

  // internal prescaler for timer operation
  tick_divider #(
    .DIV      (PRESCALE)
  ) u_prescale (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .enable   (runBit),
    .tick     (preTick)
  );

  // count pin falling edge, ignored while the pin is driven by clock-out
  fall_edge_detect u_pin_edge (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pinIn     (countPinIn),
    .fallPulse (pinFall)
  );

  // direction pin falling edge for external reload or capture
  fall_edge_detect u_dir_edge (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pinIn     (directionPin),
    .fallPulse (dirFall)
  );

  // count source and direction
  always_comb
  begin
    if (!runBit)
      step = 1'b0;
    else if (clkOutMode || baudMode)
      step = state_r.halfPhase;
    else if (counterSel)
      step = pinFall;
    else
      step = preTick;
    countDown = downMode & ~directionPin;
  end

  // byte cascade: low byte carries into high byte
  always_comb
  begin
    {lowCarry, lowNext} = {1'b0, state_r.count[7:0]} + 9'h001;
    highNext = state_r.count[15:8] + {7'h00, lowCarry};
    upNext = {highNext, lowNext};
  end

  assign wrap     = step && (countDown ? (state_r.count == state_r.reload)
                                      : (state_r.count == reload_timer_pkg::COUNT_TOP));
  assign extEvent = runBit && state_r.control[reload_timer_pkg::CTL_EXTEN] && dirFall && !downMode;

  // apb decode
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && !penable && !pwrite;
  always_comb
  begin
    case (paddr)
      reload_timer_pkg::OFS_CONTROL,
      reload_timer_pkg::OFS_MODE,
      reload_timer_pkg::OFS_CNT_LOW,
      reload_timer_pkg::OFS_CNT_HIGH,
      reload_timer_pkg::OFS_RLD_LOW,
      reload_timer_pkg::OFS_RLD_HIGH: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  // next state
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rxTick = 1'b0;
    state_nxt.txTick = 1'b0;
    // half rate phase runs only while counting so a stop freezes the output
    if (runBit && (clkOutMode || baudMode))
      state_nxt.halfPhase = ~state_r.halfPhase;
    // software writes first, hardware events below win over them
    if (wrAccess)
    begin
      case (paddr)
        reload_timer_pkg::OFS_CONTROL:  state_nxt.control = pwdata[7:0];
        reload_timer_pkg::OFS_MODE:     state_nxt.mode = pwdata[1:0] & reload_timer_pkg::MODE_MASK;
        reload_timer_pkg::OFS_CNT_LOW:  state_nxt.count[7:0] = pwdata[7:0];
        reload_timer_pkg::OFS_CNT_HIGH: state_nxt.count[15:8] = pwdata[7:0];
        reload_timer_pkg::OFS_RLD_LOW:  state_nxt.reload[7:0] = pwdata[7:0];
        reload_timer_pkg::OFS_RLD_HIGH: state_nxt.reload[15:8] = pwdata[7:0];
        default: state_nxt.count = state_nxt.count;
      endcase
    end
    // counting
    if (step)
    begin
      if (wrap)
      begin
        if (countDown)
          state_nxt.count = reload_timer_pkg::COUNT_TOP;
        else if (!captureSel || baudMode || clkOutMode)
          state_nxt.count = state_r.reload;
        else
          state_nxt.count = upNext; // capture mode rolls over
        // flag only outside baud and clock-out use, set wins over clear
        if (!baudMode && !clkOutMode)
          state_nxt.control[reload_timer_pkg::CTL_OVERFLOW] = 1'b1;
        if (downMode)
          state_nxt.control[reload_timer_pkg::CTL_EXTFLAG] = ~state_r.control[reload_timer_pkg::CTL_EXTFLAG];
        if (clkOutMode)
          state_nxt.clkOut = ~state_r.clkOut;
        state_nxt.rxTick = rxSel;
        state_nxt.txTick = txSel;
      end
      else if (countDown)
        state_nxt.count = state_r.count - 16'h0001;
      else
        state_nxt.count = upNext;
    end
    // external direction pin event
    if (extEvent)
    begin
      if (captureSel && !baudMode)
        state_nxt.reload = state_r.count; // capture into reload registers
      else
        state_nxt.count = state_r.reload;
      state_nxt.control[reload_timer_pkg::CTL_EXTFLAG] = 1'b1;
    end
    // read data captured in the setup cycle, held through the access phase
    if (rdAccess)
    begin
      case (paddr)
        reload_timer_pkg::OFS_CONTROL:  state_nxt.rdata = {24'h000000, state_r.control};
        reload_timer_pkg::OFS_MODE:     state_nxt.rdata = {30'h00000000, state_r.mode};
        reload_timer_pkg::OFS_CNT_LOW:  state_nxt.rdata = {24'h000000, state_r.count[7:0]};
        reload_timer_pkg::OFS_CNT_HIGH: state_nxt.rdata = {24'h000000, state_r.count[15:8]};
        reload_timer_pkg::OFS_RLD_LOW:  state_nxt.rdata = {24'h000000, state_r.reload[7:0]};
        reload_timer_pkg::OFS_RLD_HIGH: state_nxt.rdata = {24'h000000, state_r.reload[15:8]};
        default:                        state_nxt.rdata = reload_timer_pkg::RDATA_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_r.control   <= reload_timer_pkg::CONTROL_RESET;
      state_r.mode      <= reload_timer_pkg::MODE_RESET[1:0];
      state_r.count     <= 16'h0000;
      state_r.reload    <= 16'h0000;
      state_r.halfPhase <= 1'b0;
      state_r.clkOut    <= 1'b0;
      state_r.rxTick    <= 1'b0;
      state_r.txTick    <= 1'b0;
      state_r.rdata     <= reload_timer_pkg::RDATA_ZERO;
    end
    else
      state_r <= state_nxt;
  end

  // outputs
  assign prdata      = state_r.rdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addrOk;
  assign countPinOut = state_r.clkOut;
  assign countPinOe  = clkOutMode;
  assign timerIrq    = state_r.control[reload_timer_pkg::CTL_OVERFLOW]
                     | (state_r.control[reload_timer_pkg::CTL_EXTFLAG] & ~downMode);
  assign rxBaudTick  = state_r.rxTick;
  assign txBaudTick  = state_r.txTick;
endmodule
`default_nettype wire

/* hdl/reload_timer_pkg.sv */
// package: register map, field positions, reset values and timing constants of the reload timer
package reload_timer_pkg;
  // register word offsets (byte addresses on the apb bus)
  localparam logic [7:0] OFS_CONTROL  = 8'h00; // timer_control_reg
  localparam logic [7:0] OFS_MODE     = 8'h04; // timer_mode_reg
  localparam logic [7:0] OFS_CNT_LOW  = 8'h08; // count_low_byte
  localparam logic [7:0] OFS_CNT_HIGH = 8'h0c; // count_high_byte
  localparam logic [7:0] OFS_RLD_LOW  = 8'h10; // reload_low_byte
  localparam logic [7:0] OFS_RLD_HIGH = 8'h14; // reload_high_byte
  // control register fields
  localparam int CTL_OVERFLOW  = 7;
  localparam int CTL_EXTFLAG   = 6;
  localparam int CTL_RXCLK     = 5;
  localparam int CTL_TXCLK     = 4;
  localparam int CTL_EXTEN     = 3;
  localparam int CTL_RUN       = 2;
  localparam int CTL_COUNTER   = 1;
  localparam int CTL_CAPTURE   = 0;
  // mode register fields
  localparam int MOD_CLKOUT    = 1;
  localparam int MOD_DOWNEN    = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [1:0] MODE_MASK     = 2'h3;
  // internal timer source divides the peripheral clock by this figure
  localparam int          TIMER_DIV     = 12;
  localparam logic [3:0]  TIMER_DIV_TOP = 4'(TIMER_DIV - 1);
  localparam logic [15:0] COUNT_TOP     = 16'hffff;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
endpackage

/* hdl/tick_divider.sv */
// prescaler giving one enable tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 12 // divide ratio
) (
  input  wire logic core_clk, // peripheral clock
  input  wire logic rst_b,    // synchronous reset, active low
  input  wire logic enable,   // count only while set
  output logic      tick      // one cycle pulse every DIV enabled clocks
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] TOP = W'(DIV - 1);

  initial
  begin
    if (DIV < 1)
      $error("tick_divider: DIV must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } div_s;
  div_s state_r;
  div_s state_nxt;

  // count up and wrap at the top
  always_comb
  begin
    state_nxt = state_r;
    if (!enable)
      state_nxt.cnt = '0;
    else if (state_r.cnt == TOP)
      state_nxt.cnt = '0;
    else
      state_nxt.cnt = state_r.cnt + W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state_r <= '{cnt: '0};
    else
      state_r <= state_nxt;
  end

  assign tick = enable && (state_r.cnt == TOP);
endmodule
`default_nettype wire
